// file: design/sdram_cmd_pkg.sv
// Constants and types for the SDRAM command decode and init block
package sdram_cmd_pkg;
    localparam int ADDR_W      = 13;
    localparam int BANKS       = 4;
    localparam int PRECHG_BIT  = 10;
    localparam int BL_LSB      = 0;
    localparam int BL_MSB      = 2;
    localparam int BT_BIT      = 3;
    localparam int LAT_LSB     = 4;
    localparam int LAT_MSB     = 6;
    localparam int OPM_BIT     = 9;
    localparam logic [2:0] BL_FULLPAGE = 3'h7;
    localparam int MASK_RD_LAT = 2;
    localparam int CLK_MHZ     = 25;
    localparam int PAUSE_US    = 200;
    localparam int PAUSE_CYC   = PAUSE_US * CLK_MHZ;
    localparam int INIT_REFS   = 8;

    typedef enum logic [3:0] {
        CMD_DESEL, CMD_NOP, CMD_ACT, CMD_PRE, CMD_RD, CMD_WR,
        CMD_MRS, CMD_BST, CMD_REF, CMD_SELF
    } cmd_e;

    typedef enum logic [2:0] {
        ST_RUN, ST_PDOWN, ST_SUSP, ST_SELF
    } pwr_e;
endpackage

// file: design/sdram_cmd_decoder.sv
// Strobe decode of one command edge
`timescale 1ns/1ns
module sdram_cmd_decoder
    import sdram_cmd_pkg::*;
(
    // Strobes
    input  wire logic chipSelectN,
    input  wire logic rowStrobeN,
    input  wire logic colStrobeN,
    input  wire logic writeEnableN,
    input  wire logic clkEnable,
    // Decoded
    output cmd_e      cmdKind
);
    always_comb begin
        if (chipSelectN) begin
            cmdKind = CMD_DESEL;
        end else begin
            case ({rowStrobeN, colStrobeN, writeEnableN})
                3'b011:  cmdKind = CMD_ACT;
                3'b010:  cmdKind = CMD_PRE;
                3'b101:  cmdKind = CMD_RD;
                3'b100:  cmdKind = CMD_WR;
                3'b000:  cmdKind = CMD_MRS;
                3'b110:  cmdKind = CMD_BST;
                3'b001:  cmdKind = clkEnable ? CMD_REF : CMD_SELF;
                default: cmdKind = CMD_NOP;
            endcase
        end
    end
endmodule // sdram_cmd_decoder

// file: design/sdram_command_decode_init.sv
// Command decode, power state and mode register of the SDRAM
`timescale 1ns/1ns
module sdram_command_decode_init
    import sdram_cmd_pkg::*;
(
    // Clock and reset
    input  wire logic              clk_sys,
    input  wire logic              resetn,
    // Command bus
    input  wire logic              chipSelectN,
    input  wire logic              rowStrobeN,
    input  wire logic              colStrobeN,
    input  wire logic              writeEnableN,
    input  wire logic              clkEnable,
    input  wire logic              dataMask,
    input  wire logic              bank_select_lo,
    input  wire logic              bank_select_hi,
    input  wire logic [ADDR_W-1:0] addr,
    // Burst status from the data path
    input  wire logic              burstDone,
    // Command outputs
    output logic                   activatePulse,
    output logic                   readPulse,
    output logic                   writePulse,
    output logic                   auto_precharge_flag,
    output logic [1:0]             cmdBank,
    output logic [ADDR_W-1:0]      cmdAddr,
    output logic [BANKS-1:0]       prechargeBanks,
    output logic                   column_before_row_refresh,
    output logic                   burstStopPulse,
    output logic                   writeBlocked,
    output logic                   readOutEnable,
    // Power and mode state
    output logic                   powerDown,
    output logic                   clockSuspend,
    output logic                   selfRefresh,
    output logic                   burstActive,
    output logic                   modeValid,
    output logic [2:0]             burstLength,
    output logic                   burstInterleave,
    output logic [2:0]             readLatency,
    output logic                   singleWrite
);
    cmd_e       cmdKind;
    pwr_e       pwr_reg, pwr_next;
    logic       ckePrev_reg, ckePrev_next;
    logic       accept;
    logic [1:0] bankSel;
    logic       burst_reg, burst_next;
    logic       valid_reg, valid_next;
    logic [9:0] mode_reg, mode_next;
    logic [MASK_RD_LAT-1:0] maskPipe_reg, maskPipe_next;
    logic       act_next, rd_next, wr_next, autoPre_next, ref_next, bst_next, wb_next;
    logic [1:0] bank_next;
    logic [ADDR_W-1:0] addr_next;
    logic [BANKS-1:0] pre_next;

    sdram_cmd_decoder u_dec (
        .chipSelectN (chipSelectN),
        .rowStrobeN  (rowStrobeN),
        .colStrobeN  (colStrobeN),
        .writeEnableN(writeEnableN),
        .clkEnable   (clkEnable),
        .cmdKind     (cmdKind)
    );

    assign bankSel = {bank_select_hi, bank_select_lo};

    assign accept = ckePrev_reg && (pwr_reg == ST_RUN);

    // ----------------------------------------
    // Command and power state
    // ----------------------------------------
    always_comb begin
        pwr_next      = pwr_reg;
        ckePrev_next  = clkEnable;
        burst_next    = burst_reg;
        valid_next    = valid_reg;
        mode_next     = mode_reg;
        act_next      = 1'b0;
        rd_next       = 1'b0;
        wr_next       = 1'b0;
        autoPre_next  = 1'b0;
        ref_next      = 1'b0;
        bst_next      = 1'b0;
        bank_next     = bankSel;
        addr_next     = addr;
        pre_next      = '0;
        wb_next       = dataMask;
        maskPipe_next = {maskPipe_reg[MASK_RD_LAT-2:0], dataMask};
        if (burstDone) begin
            burst_next = 1'b0;
        end
        case (pwr_reg)
            ST_RUN: begin
                if (accept) begin
                    case (cmdKind)
                        CMD_ACT: act_next = 1'b1;
                        CMD_RD, CMD_WR: begin
                            rd_next    = (cmdKind == CMD_RD);
                            wr_next    = (cmdKind == CMD_WR);
                            autoPre_next = addr[PRECHG_BIT];
                            burst_next = 1'b1;
                        end
                        CMD_PRE: begin
                            pre_next = addr[PRECHG_BIT] ? '1 : BANKS'(1) << bankSel;
                        end
                        CMD_MRS: begin
                            mode_next  = addr[9:0];
                            valid_next = 1'b1;
                        end
                        CMD_BST: begin
                            if (burst_reg && mode_reg[BL_MSB:BL_LSB] == BL_FULLPAGE) begin
                                bst_next   = 1'b1;
                                burst_next = 1'b0;
                            end
                        end
                        CMD_REF: ref_next = 1'b1;
                        CMD_SELF: pwr_next = ST_SELF;
                        default: begin
                            if (!clkEnable) begin
                                pwr_next = burst_reg ? ST_SUSP : ST_PDOWN;
                            end
                        end
                    endcase
                end
            end
            ST_PDOWN, ST_SUSP: begin
                if (clkEnable) begin
                    pwr_next = ST_RUN;
                end
            end
            default: begin
                if (clkEnable) begin
                    pwr_next = ST_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            pwr_reg      <= ST_RUN;
            ckePrev_reg  <= 1'b0;
            burst_reg    <= 1'b0;
            valid_reg    <= 1'b0;
            mode_reg     <= 10'h000;
            maskPipe_reg <= '1;
            activatePulse <= 1'b0;
            readPulse    <= 1'b0;
            writePulse   <= 1'b0;
            auto_precharge_flag <= 1'b0;
            column_before_row_refresh <= 1'b0;
            burstStopPulse <= 1'b0;
            writeBlocked <= 1'b1;
            cmdBank      <= 2'h0;
            cmdAddr      <= '0;
            prechargeBanks <= '0;
        end else begin
            pwr_reg      <= pwr_next;
            ckePrev_reg  <= ckePrev_next;
            burst_reg    <= burst_next;
            valid_reg    <= valid_next;
            mode_reg     <= mode_next;
            maskPipe_reg <= maskPipe_next;
            activatePulse <= act_next;
            readPulse    <= rd_next;
            writePulse   <= wr_next;
            auto_precharge_flag <= autoPre_next;
            column_before_row_refresh <= ref_next;
            burstStopPulse <= bst_next;
            writeBlocked <= wb_next;
            cmdBank      <= bank_next;
            cmdAddr      <= addr_next;
            prechargeBanks <= pre_next;
        end
    end

    assign readOutEnable   = !maskPipe_reg[MASK_RD_LAT-1];
    assign powerDown       = (pwr_reg == ST_PDOWN);
    assign clockSuspend    = (pwr_reg == ST_SUSP);
    assign selfRefresh     = (pwr_reg == ST_SELF);
    assign burstActive     = burst_reg;
    assign modeValid       = valid_reg;
    assign burstLength     = mode_reg[BL_MSB:BL_LSB];
    assign burstInterleave = mode_reg[BT_BIT];
    assign readLatency     = mode_reg[LAT_MSB:LAT_LSB];
    assign singleWrite     = mode_reg[OPM_BIT];

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    sequence mrsTaken;
        accept && cmdKind == CMD_MRS;
    endsequence

    AST_MRS_LOAD: assert property (@(posedge clk_sys) disable iff (!resetn)
        mrsTaken |=> (mode_reg == $past(addr[9:0]) && modeValid))
        else $error("mode register not loaded from address");
    AST_MODE_INVALID: assert property (@(posedge clk_sys) disable iff (!resetn)
        !$past(resetn) |-> !modeValid)
        else $error("mode valid right after reset");
    AST_PRE_ALL: assert property (@(posedge clk_sys) disable iff (!resetn)
        (accept && cmdKind == CMD_PRE && addr[PRECHG_BIT]) |=> prechargeBanks == 4'hF)
        else $error("precharge all missed a bank");
    AST_AUTOPRE_FLAG: assert property (@(posedge clk_sys) disable iff (!resetn)
        (accept && cmdKind == CMD_RD) |=>
            readPulse && auto_precharge_flag == $past(addr[PRECHG_BIT]))
        else $error("auto precharge flag wrong");
    AST_CKE_GATE: assert property (@(posedge clk_sys) disable iff (!resetn)
        (!ckePrev_reg && cmdKind == CMD_ACT) |=> !activatePulse)
        else $error("command taken with clock enable low before");
    AST_PDOWN: assert property (@(posedge clk_sys) disable iff (!resetn)
        (accept && cmdKind == CMD_NOP && !clkEnable && !burst_reg) |=> powerDown)
        else $error("power-down not entered");
    AST_SELF: assert property (@(posedge clk_sys) disable iff (!resetn)
        selfRefresh && !clkEnable |=> selfRefresh && !readPulse)
        else $error("self refresh left without clock enable");
    AST_RDMASK: assert property (@(posedge clk_sys) disable iff (!resetn)
        dataMask ##1 1'b1 |=> !readOutEnable)
        else $error("read mask latency not two");
    AST_WRMASK: assert property (@(posedge clk_sys) disable iff (!resetn)
        dataMask |=> writeBlocked)
        else $error("write mask not applied");
endmodule // sdram_command_decode_init

// file: tb/sdram_ctrl_model.sv
// Memory controller model that drives the SDRAM command bus
`timescale 1ns/1ns
module sdram_ctrl_model
    import sdram_cmd_pkg::*;
(
    // Clock
    input  wire logic              clk_sys,
    // Command bus
    output logic                   chipSelectN,
    output logic                   rowStrobeN,
    output logic                   colStrobeN,
    output logic                   writeEnableN,
    output logic                   clkEnable,
    output logic                   dataMask,
    output logic                   bank_select_lo,
    output logic                   bank_select_hi,
    output logic [ADDR_W-1:0]      addr
);
    // ------------------------------
    // Bus drive
    // ------------------------------
    // one change per edge
    task automatic send(input logic [3:0] s, input logic k, input logic [1:0] b,
                        input logic [ADDR_W-1:0] a, input logic m);
        @(posedge clk_sys);
        {chipSelectN, rowStrobeN, colStrobeN, writeEnableN} <= s;
        {clkEnable, dataMask, bank_select_hi, bank_select_lo, addr} <= {k, m, b, a};
    endtask

    task automatic pause;
        repeat (PAUSE_CYC) send(4'h7, 1'b1, 2'h0, '0, 1'b1);
    endtask

    initial begin
        {chipSelectN, rowStrobeN, colStrobeN, writeEnableN} = 4'h7;
        {clkEnable, dataMask, bank_select_hi, bank_select_lo, addr} = {4'hC, {ADDR_W{1'b0}}};
    end
endmodule // sdram_ctrl_model

// file: tb/test_sdram_command_decode_init.sv
// Self-checking bench for the SDRAM command decode and init block
`timescale 1ns/1ns
module test_sdram_command_decode_init;
    import sdram_cmd_pkg::*;
    localparam logic [3:0] ACT = 4'h3, PRE = 4'h2, RD = 4'h5, WR = 4'h4, MRS = 4'h0;
    localparam logic [3:0] NOP = 4'h7, BST = 4'h6, REF = 4'h1, DES = 4'hD;
    logic              clk_sys, resetn, burstDone, chipSelectN, rowStrobeN, colStrobeN;
    logic              writeEnableN, clkEnable, dataMask, bank_select_lo, bank_select_hi;
    logic              activatePulse, readPulse, writePulse, auto_precharge_flag;
    logic              column_before_row_refresh, burstStopPulse, writeBlocked;
    logic              readOutEnable, powerDown, clockSuspend, selfRefresh, burstActive;
    logic              modeValid, burstInterleave, singleWrite;
    logic [1:0]        cmdBank;
    logic [3:0]        prechargeBanks;
    logic [2:0]        burstLength, readLatency;
    logic [ADDR_W-1:0] addr, cmdAddr;
    logic [4:0]        pat;
    int                n_errors = 0;
    int                total_checks = 0;

    sdram_ctrl_model ctl (.clk_sys, .chipSelectN, .rowStrobeN, .colStrobeN, .writeEnableN,
        .clkEnable, .dataMask, .bank_select_lo, .bank_select_hi, .addr);
    sdram_command_decode_init dut (.clk_sys, .resetn, .chipSelectN, .rowStrobeN,
        .colStrobeN, .writeEnableN, .clkEnable, .dataMask, .bank_select_lo,
        .bank_select_hi, .addr, .burstDone, .activatePulse, .readPulse, .writePulse,
        .auto_precharge_flag, .cmdBank, .cmdAddr, .prechargeBanks,
        .column_before_row_refresh, .burstStopPulse, .writeBlocked, .readOutEnable,
        .powerDown, .clockSuspend, .selfRefresh, .burstActive, .modeValid, .burstLength,
        .burstInterleave, .readLatency, .singleWrite);

    // ------------------------------
    // Helpers
    // ------------------------------
    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Command, then a NOP, then look
    task automatic go(input logic [3:0] s, input logic [1:0] b, input logic [12:0] a);
        ctl.send(s, 1'b1, b, a, 1'b0);
        ctl.send(NOP, 1'b1, 2'h0, 13'h0, 1'b0);
        #1;
    endtask

    task automatic step(input logic [3:0] s, input logic k);
        ctl.send(s, k, 2'h0, 13'h0, 1'b0);
        #1;
    endtask

    task automatic give_verdict;
        $display("errors %0d checks %0d", n_errors, total_checks);
        if (n_errors == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ------------------------------
    // Scenarios
    // ------------------------------
    task automatic t_init;
        ctl.pause();
        ctl.send(PRE, 1'b1, 2'h1, 13'h0400, 1'b1);
        ctl.send(MRS, 1'b1, 2'h0, 13'h0235, 1'b1);
        #1 chk(prechargeBanks, 4'hF);
        chk(modeValid, 1'b0);
        ctl.send(NOP, 1'b1, 2'h0, 13'h0, 1'b1);
        #1 chk({modeValid, singleWrite, readLatency, burstInterleave, burstLength}, 9'h1B5);
        chk(burstLength, 3'h5);
        repeat (INIT_REFS) begin
            go(REF, 2'h3, 13'h1FFF);
            chk(column_before_row_refresh, 1'b1);
        end
    endtask

    task automatic t_rw;
        go(ACT, 2'h2, 13'h0123);
        chk({activatePulse, cmdBank, cmdAddr}, {1'b1, 2'h2, 13'h0123});
        go(RD, 2'h2, 13'h0400);
        chk({readPulse, auto_precharge_flag, burstActive}, 3'h7);
        go(BST, 2'h0, 13'h0);
        chk(burstStopPulse, 1'b0);
        @(posedge clk_sys) burstDone <= 1'b1;
        @(posedge clk_sys) burstDone <= 1'b0;
        // bank 2 closed by auto precharge, open bank 1
        go(ACT, 2'h1, 13'h0045);
        chk({activatePulse, cmdBank}, {1'b1, 2'h1});
        go(WR, 2'h1, 13'h0010);
        chk({writePulse, auto_precharge_flag, readPulse}, 3'h4);
        @(posedge clk_sys) burstDone <= 1'b1;
        @(posedge clk_sys) burstDone <= 1'b0;
        go(DES, 2'h1, 13'h0);
        chk({readPulse, writePulse, burstActive}, 3'h0);
        go(PRE, 2'h1, 13'h0000);
        chk(prechargeBanks, 4'h2);
    endtask

    task automatic t_mask;
        pat = 5'b01101;
        for (int i = 0; i < 5; i++) begin
            ctl.send(NOP, 1'b1, 2'h0, 13'h0, pat[i]);
            #1;
            if (i >= 1) chk(writeBlocked, pat[i-1]);
            if (i >= 2) chk(readOutEnable, !pat[i-2]);
        end
    endtask

    task automatic t_pdown;
        step(NOP, 1'b0);
        step(NOP, 1'b0);
        chk({powerDown, clockSuspend}, 2'h2);
        step(RD, 1'b1);
        step(NOP, 1'b1);
        chk({readPulse, powerDown}, 2'h0);
    endtask

    task automatic t_self;
        step(REF, 1'b0);
        step(NOP, 1'b0);
        chk({selfRefresh, column_before_row_refresh}, 2'h2);
        step(ACT, 1'b0);
        step(NOP, 1'b1);
        chk({activatePulse, selfRefresh}, 2'h1);
        step(NOP, 1'b1);
        step(NOP, 1'b1);
        chk(selfRefresh, 1'b0);
    endtask

    task automatic t_bstop;
        go(PRE, 2'h0, 13'h0400);
        go(MRS, 2'h0, 13'h0007);
        chk(burstLength, 3'h7);
        go(ACT, 2'h0, 13'h0001);
        go(RD, 2'h0, 13'h0000);
        step(NOP, 1'b0);
        step(NOP, 1'b0);
        chk({clockSuspend, powerDown, burstActive}, 3'h5);
        step(NOP, 1'b1);
        step(NOP, 1'b1);
        go(BST, 2'h0, 13'h0);
        chk({clockSuspend, burstStopPulse}, 2'h1);
        step(NOP, 1'b1);
        chk(burstActive, 1'b0);
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    initial begin
        #(40 * (PAUSE_CYC + 2000));
        n_errors++;
        give_verdict();
    end

    initial begin
        resetn = 1'b0;
        burstDone = 1'b0;
        repeat (6) @(posedge clk_sys);
        resetn <= 1'b1;
        t_init();
        t_rw();
        t_mask();
        t_pdown();
        t_self();
        t_bstop();
        give_verdict();
    end
endmodule // test_sdram_command_decode_init
